// *** cetu_top.sv ***
module cetu_top (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cetu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // acquisition events, one-cycle pulses
    input wire logic acqBegin,
    input wire logic acqFinish,
    input wire logic frameBegin,
    input wire logic frameFinish,
    input wire logic imageDropped,
    // triggers
    input wire logic frameTrigReq,
    input wire logic frameTrigInvalid,
    output logic frameTrigAccept,
    input wire logic lineTrigReq,
    input wire logic lineTrigInvalid,
    input wire logic lineTrigDefer,
    output logic lineTrigAccept,
    // io line one
    input wire logic ioLineOnePin,
    input wire logic ioLineOneIsOutput,
    input wire logic ioLineOnePulseStart,
    // control channel messages
    output logic msgValid,
    input wire logic msgReady,
    output logic [3:0] msgEvent,
    output logic msgLegacy,
    output logic [63:0] msgStamp
);
    localparam int N = cetu_pkg::NUM_EVT;
    localparam int OVR = int'(cetu_pkg::EVT_MESSAGE_OVERRUN);

    typedef struct packed {
        logic [63:0] tsCount;
        logic [63:0] tsSnap;
        cetu_pkg::cetu_src_t tsSrc;
        logic [3:0] evtSel;
        logic [N-1:0][1:0] notify;
        cetu_pkg::cetu_edge_t edgeSel;
        logic [N-1:0] pend;
        logic [N-1:0] pendLegacy;
        logic msgValid;
        logic [3:0] msgEvent;
        logic msgLegacy;
        logic [63:0] msgStamp;
        logic overrunSeen;
        logic [31:0] rdData;
        logic rdErr;
    } cetu_state_t;

    cetu_state_t s_q;
    cetu_state_t s_d;
    logic [N-1:0] ev;
    logic ioChange;
    logic setup;
    logic access;
    logic wrAcc;
    logic sendFree;
    logic found;
    logic overflow;

    function automatic logic isMapped(input logic [cetu_pkg::ADDR_W-1:0] a);
        isMapped = (a == cetu_pkg::OFF_CMD) || (a == cetu_pkg::OFF_SNAP_LO)
            || (a == cetu_pkg::OFF_SNAP_HI) || (a == cetu_pkg::OFF_SRC)
            || (a == cetu_pkg::OFF_TICKS) || (a == cetu_pkg::OFF_EVT_SEL)
            || (a == cetu_pkg::OFF_NOTIFY) || (a == cetu_pkg::OFF_EDGE)
            || (a == cetu_pkg::OFF_STATUS);
    endfunction

    function automatic logic [31:0] regRead(input cetu_state_t s,
        input logic [cetu_pkg::ADDR_W-1:0] a);
        regRead = cetu_pkg::RD_ZERO;
        if (a == cetu_pkg::OFF_SNAP_LO) begin
            regRead = s.tsSnap[31:0];
        end else if (a == cetu_pkg::OFF_SNAP_HI) begin
            regRead = s.tsSnap[63:32];
        end else if (a == cetu_pkg::OFF_SRC) begin
            regRead[0] = s.tsSrc;
        end else if (a == cetu_pkg::OFF_TICKS) begin
            regRead = cetu_pkg::TICKS_PER_SEC;
        end else if (a == cetu_pkg::OFF_EVT_SEL) begin
            regRead[3:0] = s.evtSel;
        end else if (a == cetu_pkg::OFF_NOTIFY) begin
            regRead[1:0] = s.notify[s.evtSel];
        end else if (a == cetu_pkg::OFF_EDGE) begin
            regRead[1:0] = s.edgeSel;
        end else if (a == cetu_pkg::OFF_STATUS) begin
            regRead[cetu_pkg::STAT_BUSY_BIT] = s.msgValid;
            regRead[cetu_pkg::STAT_OVERRUN_BIT] = s.overrunSeen;
        end
    endfunction

    cetu_line_edge u_line_edge (
        .clk(clk),
        .srst(srst),
        .linePin(ioLineOnePin),
        .isOutput(ioLineOneIsOutput),
        .pulseStart(ioLineOnePulseStart),
        .edgeSel(s_q.edgeSel),
        .changePulse(ioChange)
    );

    // trigger qualification
    assign frameTrigAccept = frameTrigReq & ~frameTrigInvalid;
    assign lineTrigAccept = lineTrigReq & ~lineTrigInvalid;

    always_comb begin
        ev = '0;
        ev[int'(cetu_pkg::EVT_ACQ_BEGIN)] = acqBegin;
        ev[int'(cetu_pkg::EVT_ACQ_FINISH)] = acqFinish;
        ev[int'(cetu_pkg::EVT_FRAME_BEGIN)] = frameBegin;
        ev[int'(cetu_pkg::EVT_FRAME_FINISH)] = frameFinish;
        ev[int'(cetu_pkg::EVT_FRAME_TRIG_OK)] = frameTrigAccept;
        ev[int'(cetu_pkg::EVT_FRAME_TRIG_REJECT)] =
            frameTrigReq & frameTrigInvalid;
        ev[int'(cetu_pkg::EVT_IMAGE_DROPPED)] = imageDropped;
        ev[int'(cetu_pkg::EVT_LINE_TRIG_REJECT)] =
            lineTrigReq & lineTrigInvalid & ~lineTrigDefer;
        ev[int'(cetu_pkg::EVT_LINE_TRIG_DEFERRED)] =
            lineTrigReq & lineTrigInvalid & lineTrigDefer;
        ev[int'(cetu_pkg::EVT_IO_LINE_ONE_CHANGE)] = ioChange;
    end

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrAcc = access & pwrite & isMapped(paddr);

    always_comb begin
        s_d = s_q;
        found = 1'b0;
        overflow = 1'b0;
        // counter runs on the on-chip clock
        if (s_q.tsSrc == cetu_pkg::TS_SRC_ONCHIP_CLOCK) begin
            s_d.tsCount = s_q.tsCount + cetu_pkg::TS_ONE;
        end
        // read data captured in setup phase
        if (setup) begin
            s_d.rdData = regRead(s_q, paddr);
            s_d.rdErr = ~isMapped(paddr);
        end
        if (wrAcc) begin
            if (paddr == cetu_pkg::OFF_CMD) begin
                if (pwdata[cetu_pkg::CMD_LATCH_BIT]) begin
                    s_d.tsSnap = s_q.tsCount;
                end
                if (pwdata[cetu_pkg::CMD_CLEAR_BIT]) begin
                    s_d.tsCount = cetu_pkg::TS_ZERO;
                end
            end else if (paddr == cetu_pkg::OFF_SRC) begin
                if (pwdata[0] == cetu_pkg::TS_SRC_ONCHIP_CLOCK) begin
                    s_d.tsSrc = cetu_pkg::TS_SRC_ONCHIP_CLOCK;
                end
            end else if (paddr == cetu_pkg::OFF_EVT_SEL) begin
                if (pwdata[31:4] == 28'h0000000
                    && pwdata[3:0] <= cetu_pkg::EVT_MESSAGE_OVERRUN) begin
                    s_d.evtSel = pwdata[3:0];
                end
            end else if (paddr == cetu_pkg::OFF_NOTIFY) begin
                if (pwdata[1:0] != 2'h3) begin
                    s_d.notify[s_q.evtSel] = pwdata[1:0];
                end
            end else if (paddr == cetu_pkg::OFF_EDGE) begin
                if (pwdata[1:0] != 2'h3) begin
                    s_d.edgeSel = cetu_pkg::cetu_edge_t'(pwdata[1:0]);
                end
            end else if (paddr == cetu_pkg::OFF_STATUS) begin
                if (pwdata[cetu_pkg::STAT_OVERRUN_BIT]) begin
                    s_d.overrunSeen = 1'b0;
                end
            end
        end
        // message sender, lowest pending code first
        sendFree = ~s_q.msgValid | msgReady;
        if (s_q.msgValid & msgReady) begin
            s_d.msgValid = 1'b0;
        end
        if (sendFree) begin
            for (int i = 0; i < N; i++) begin
                if (!found && s_q.pend[i]) begin
                    found = 1'b1;
                    s_d.msgValid = 1'b1;
                    s_d.msgEvent = 4'(i);
                    s_d.msgLegacy = s_q.pendLegacy[i];
                    s_d.msgStamp = s_q.tsCount;
                    s_d.pend[i] = 1'b0;
                end
            end
        end
        // event capture, a set wins over the send clear
        for (int i = 0; i < N; i++) begin
            if (ev[i] && s_q.notify[i] != cetu_pkg::NOTIFY_OFF) begin
                if (s_q.pend[i] && s_d.pend[i]) begin
                    overflow = 1'b1;
                end else begin
                    s_d.pend[i] = 1'b1;
                    s_d.pendLegacy[i] =
                        (s_q.notify[i] == cetu_pkg::NOTIFY_LEGACY);
                end
            end
        end
        if (overflow) begin
            for (int i = 0; i < N; i++) begin
                if (i != OVR) begin
                    s_d.notify[i] = cetu_pkg::NOTIFY_OFF;
                end
            end
            s_d.pend[OVR] = 1'b1;
            s_d.pendLegacy[OVR] =
                (s_q.notify[OVR] == cetu_pkg::NOTIFY_LEGACY);
            s_d.overrunSeen = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.evtSel <= cetu_pkg::SEL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers with no wait state
    assign pready = 1'b1;
    assign pslverr = access & s_q.rdErr;
    assign prdata = s_q.rdData;
    assign msgValid = s_q.msgValid;
    assign msgEvent = s_q.msgEvent;
    assign msgLegacy = s_q.msgLegacy;
    assign msgStamp = s_q.msgStamp;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    localparam logic [63:0] TS_ONE_L = cetu_pkg::TS_ONE;
    logic wrCmd;
    assign wrCmd = wrAcc && paddr == cetu_pkg::OFF_CMD;

    snap_latch_a: assert property (
        wrCmd && pwdata[cetu_pkg::CMD_LATCH_BIT]
        |=> s_q.tsSnap == $past(s_q.tsCount))
        else $error("snapshot did not take the counter");

    snap_hold_a: assert property (
        !(wrCmd && pwdata[cetu_pkg::CMD_LATCH_BIT])
        |=> s_q.tsSnap == $past(s_q.tsSnap))
        else $error("snapshot changed without latch");

    ts_clear_a: assert property (
        wrCmd && pwdata[cetu_pkg::CMD_CLEAR_BIT]
        |=> s_q.tsCount == cetu_pkg::TS_ZERO ##1 s_q.tsCount == TS_ONE_L)
        else $error("counter not cleared");

    ts_run_a: assert property (
        !(wrCmd && pwdata[cetu_pkg::CMD_CLEAR_BIT])
        |=> s_q.tsCount == $past(s_q.tsCount) + TS_ONE_L)
        else $error("counter did not advance");

    tick_read_a: assert property (
        setup && paddr == cetu_pkg::OFF_TICKS
        |=> prdata == cetu_pkg::TICKS_PER_SEC && !pslverr)
        else $error("tick rate read wrong");

    sel_write_a: assert property (
        wrAcc && paddr == cetu_pkg::OFF_NOTIFY && pwdata[1:0] != 2'h3
        && !overflow
        |=> s_q.notify[$past(s_q.evtSel)] == $past(pwdata[1:0]))
        else $error("enable not stored for selected event");

    evt_queue_a: assert property (
        ev[int'(cetu_pkg::EVT_ACQ_BEGIN)]
        && s_q.notify[int'(cetu_pkg::EVT_ACQ_BEGIN)] != cetu_pkg::NOTIFY_OFF
        && !s_q.pend[int'(cetu_pkg::EVT_ACQ_BEGIN)]
        |=> s_q.pend[int'(cetu_pkg::EVT_ACQ_BEGIN)])
        else $error("enabled event not queued");

    evt_drop_a: assert property (
        !ev[int'(cetu_pkg::EVT_IMAGE_DROPPED)]
        && !s_q.pend[int'(cetu_pkg::EVT_IMAGE_DROPPED)]
        |=> !s_q.pend[int'(cetu_pkg::EVT_IMAGE_DROPPED)])
        else $error("event queued without cause");

    trig_reject_a: assert property (
        frameTrigReq && frameTrigInvalid
        |-> !frameTrigAccept
        && ev[int'(cetu_pkg::EVT_FRAME_TRIG_REJECT)])
        else $error("invalid frame trigger accepted");

    overrun_a: assert property (
        overflow |=> s_q.pend[OVR] && s_q.overrunSeen
        && s_q.notify[int'(cetu_pkg::EVT_ACQ_BEGIN)] == cetu_pkg::NOTIFY_OFF)
        else $error("overrun did not disable events");

    msg_hold_a: assert property (
        msgValid && !msgReady |=> $stable(msgEvent) && $stable(msgStamp)
        && msgValid)
        else $error("message changed while stalled");
endmodule

// *** cetu_pkg.sv ***
// What this block does
// - latch command copies running counter to snapshot
// - snapshot is read-only, full 64 bits
// - clear command zeroes the timestamp counter
// - source select; on-chip clock advances counter
// - read-only ticks per second value
// - selector picks event for enable access
// - acquisition begin event when enabled
// - acquisition finish event when enabled
// - frame begin event at first exposure delay
// - frame finish event when enabled
// - accepted frame trigger event when enabled
// - invalid-region frame trigger rejected and reported
// - image dropped event on memory exhaustion
// - invalid-region line trigger rejected and reported
// - deferred line trigger reported when enabled
// - io line one change event when enabled
// - enable setting: off, on, legacy
// - input edge select; outputs fire at pulse start
// - overrun disables all events except overrun, sends overrun event
package cetu_pkg;
    localparam int NUM_EVT = 11;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SNAP_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SNAP_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SRC = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_TICKS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVT_SEL = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_NOTIFY = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_EDGE = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;

    // field positions
    localparam int CMD_LATCH_BIT = 0;
    localparam int CMD_CLEAR_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OVERRUN_BIT = 1;

    // one tick per 250 MHz clock
    localparam logic [31:0] TICKS_PER_SEC = 32'h0EE6B280;
    localparam logic [63:0] TS_ONE = 64'h0000000000000001;
    localparam logic [63:0] TS_ZERO = 64'h0000000000000000;
    localparam logic [31:0] RD_ZERO = 32'h00000000;
    localparam logic [3:0] SEL_RST = 4'h0;

    typedef enum logic [1:0] {
        NOTIFY_OFF = 2'h0,
        NOTIFY_ON = 2'h1,
        NOTIFY_LEGACY = 2'h2
    } cetu_notify_t;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_ANY = 2'h2
    } cetu_edge_t;

    typedef enum logic [0:0] {
        TS_SRC_ONCHIP_CLOCK = 1'h0
    } cetu_src_t;

    typedef enum logic [3:0] {
        EVT_ACQ_BEGIN = 4'h0,
        EVT_ACQ_FINISH = 4'h1,
        EVT_FRAME_BEGIN = 4'h2,
        EVT_FRAME_FINISH = 4'h3,
        EVT_FRAME_TRIG_OK = 4'h4,
        EVT_FRAME_TRIG_REJECT = 4'h5,
        EVT_IMAGE_DROPPED = 4'h6,
        EVT_LINE_TRIG_REJECT = 4'h7,
        EVT_LINE_TRIG_DEFERRED = 4'h8,
        EVT_IO_LINE_ONE_CHANGE = 4'h9,
        EVT_MESSAGE_OVERRUN = 4'hA
    } cetu_evt_t;
endpackage

// *** cetu_line_edge.sv ***
module cetu_line_edge (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // line
    input wire logic linePin,
    input wire logic isOutput,
    input wire logic pulseStart,
    input wire cetu_pkg::cetu_edge_t edgeSel,
    // event
    output logic changePulse
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic pulse;
    } cetu_edge_state_t;

    cetu_edge_state_t s_q;
    cetu_edge_state_t s_d;
    logic rise;
    logic fall;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = linePin;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        rise = s_q.sync2 & ~s_q.prev;
        fall = ~s_q.sync2 & s_q.prev;
        if (isOutput) begin
            s_d.pulse = pulseStart;
        end else if (edgeSel == cetu_pkg::EDGE_RISE) begin
            s_d.pulse = rise;
        end else if (edgeSel == cetu_pkg::EDGE_FALL) begin
            s_d.pulse = fall;
        end else begin
            s_d.pulse = rise | fall;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign changePulse = s_q.pulse;
endmodule

// *** test_cetu_top.sv ***
module test_cetu_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [cetu_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic acqBegin, acqFinish, frameBegin, frameFinish, imageDropped;
    logic frameTrigReq, frameTrigInvalid, frameTrigAccept;
    logic lineTrigReq, lineTrigInvalid, lineTrigDefer, lineTrigAccept;
    logic ioLineOnePin, ioLineOneIsOutput, ioLineOnePulseStart;
    logic msgValid, msgReady, msgLegacy;
    logic [3:0] msgEvent;
    logic [63:0] msgStamp;
    int errorCnt, nTests, i;

    cetu_top u_dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acqBegin(acqBegin), .acqFinish(acqFinish),
        .frameBegin(frameBegin), .frameFinish(frameFinish),
        .imageDropped(imageDropped), .frameTrigReq(frameTrigReq),
        .frameTrigInvalid(frameTrigInvalid),
        .frameTrigAccept(frameTrigAccept), .lineTrigReq(lineTrigReq),
        .lineTrigInvalid(lineTrigInvalid), .lineTrigDefer(lineTrigDefer),
        .lineTrigAccept(lineTrigAccept), .ioLineOnePin(ioLineOnePin),
        .ioLineOneIsOutput(ioLineOneIsOutput),
        .ioLineOnePulseStart(ioLineOnePulseStart), .msgValid(msgValid),
        .msgReady(msgReady), .msgEvent(msgEvent), .msgLegacy(msgLegacy),
        .msgStamp(msgStamp));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [63:0] seen,
            input logic [63:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
            input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(what, 64'(rd), 64'(exp));
    endtask

    // one-cycle event stimulus by event code
    task automatic fire(input logic [3:0] c);
        @(posedge clk);
        case (c)
            4'h0: acqBegin <= 1'b1;
            4'h1: acqFinish <= 1'b1;
            4'h2: frameBegin <= 1'b1;
            4'h3: frameFinish <= 1'b1;
            4'h4: frameTrigReq <= 1'b1;
            4'h5: begin
                frameTrigReq <= 1'b1;
                frameTrigInvalid <= 1'b1;
            end
            4'h6: imageDropped <= 1'b1;
            4'h7: begin
                lineTrigReq <= 1'b1;
                lineTrigInvalid <= 1'b1;
            end
            4'h8: begin
                lineTrigReq <= 1'b1;
                lineTrigInvalid <= 1'b1;
                lineTrigDefer <= 1'b1;
            end
            4'hE: lineTrigReq <= 1'b1;
            4'hF: ioLineOnePulseStart <= 1'b1;
            default: ioLineOnePin <= ~ioLineOnePin;
        endcase
        @(posedge clk);
        if (c == 4'h4) chk("frame accept", 64'(frameTrigAccept), 64'h1);
        if (c == 4'h5) chk("frame reject", 64'(frameTrigAccept), 64'h0);
        if (c == 4'h7) chk("line reject", 64'(lineTrigAccept), 64'h0);
        if (c == 4'h8) chk("line deferred", 64'(lineTrigAccept), 64'h0);
        if (c == 4'hE) chk("line accept", 64'(lineTrigAccept), 64'h1);
        {acqBegin, acqFinish, frameBegin, frameFinish} <= 4'h0;
        {frameTrigReq, frameTrigInvalid, imageDropped} <= 3'h0;
        {lineTrigReq, lineTrigInvalid, lineTrigDefer} <= 3'h0;
        ioLineOnePulseStart <= 1'b0;
    endtask

    // waits up to 30 cycles for a message and checks its code and legacy flag
    task automatic wait_msg(input string what, input logic [3:0] c,
            input logic leg);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (msgValid !== 1'b1 && n < 30);
        chk("message valid", 64'(msgValid), 64'h1);
        chk(what, 64'(msgEvent), 64'(c));
        chk("legacy flag", 64'(msgLegacy), 64'(leg));
    endtask

    task automatic quiet(input string what);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge clk);
            if (msgValid === 1'b1) seen = 1'b1;
        end
        chk(what, 64'(seen), 64'h0);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        tally_and_finish();
    end

    initial begin
        {srst, msgReady} = 2'h3;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {acqBegin, acqFinish, frameBegin, frameFinish, imageDropped} = '0;
        {frameTrigReq, frameTrigInvalid, lineTrigReq} = '0;
        {lineTrigInvalid, lineTrigDefer, ioLineOnePin} = '0;
        {ioLineOneIsOutput, ioLineOnePulseStart, errorCnt, nTests} = '0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rdchk("ticks", cetu_pkg::OFF_TICKS, cetu_pkg::TICKS_PER_SEC);
        rdchk("source", cetu_pkg::OFF_SRC, 32'h00000000);
        rdchk("selector", cetu_pkg::OFF_EVT_SEL, 32'h00000000);
        rdchk("enable", cetu_pkg::OFF_NOTIFY, 32'h00000000);
        rdchk("command", cetu_pkg::OFF_CMD, 32'h00000000);
        apb(1'b0, 8'h40, 32'h00000000);
        chk("unmapped error", 64'(err), 64'h1);
        chk("unmapped data", 64'(rd), 64'h0);
        apb(1'b1, cetu_pkg::OFF_SRC, 32'h00000001);
        rdchk("bad source", cetu_pkg::OFF_SRC, 32'h00000000);
        apb(1'b1, cetu_pkg::OFF_SNAP_LO, 32'hFFFFFFFF);
        rdchk("snapshot ro", cetu_pkg::OFF_SNAP_LO, 32'h00000000);
        apb(1'b1, cetu_pkg::OFF_EVT_SEL, 32'h0000000B);
        rdchk("bad selector", cetu_pkg::OFF_EVT_SEL, 32'h00000000);
        $display("registers test done");
        // clear, then latch three cycles later sees counter 2
        apb(1'b1, cetu_pkg::OFF_CMD, 32'h00000002);
        apb(1'b1, cetu_pkg::OFF_CMD, 32'h00000001);
        rdchk("snapshot lo", cetu_pkg::OFF_SNAP_LO, 32'h00000002);
        rdchk("snapshot hi", cetu_pkg::OFF_SNAP_HI, 32'h00000000);
        apb(1'b1, cetu_pkg::OFF_CMD, 32'h00000001);
        rdchk("relatch lo", cetu_pkg::OFF_SNAP_LO, 32'h0000000B);
        $display("timestamp test done");
        for (i = 0; i < 10; i++) begin
            apb(1'b1, cetu_pkg::OFF_EVT_SEL, 32'(i));
            apb(1'b1, cetu_pkg::OFF_NOTIFY, (i % 2) ? 32'h2 : 32'h1);
            fire(4'(i));
            wait_msg("event code", 4'(i), 1'(i % 2));
        end
        apb(1'b1, cetu_pkg::OFF_EVT_SEL, 32'h00000000);
        apb(1'b1, cetu_pkg::OFF_NOTIFY, 32'h00000000);
        fire(4'h0);
        fire(4'hE);
        quiet("disabled event");
        $display("event test done");
        apb(1'b1, cetu_pkg::OFF_EVT_SEL, 32'h00000009);
        apb(1'b1, cetu_pkg::OFF_EDGE, 32'h00000001);
        fire(4'h9);
        wait_msg("falling edge", 4'h9, 1'b1);
        fire(4'h9);
        quiet("rising ignored");
        apb(1'b1, cetu_pkg::OFF_EDGE, 32'h00000002);
        fire(4'h9);
        wait_msg("any edge fall", 4'h9, 1'b1);
        fire(4'h9);
        wait_msg("any edge rise", 4'h9, 1'b1);
        @(posedge clk);
        ioLineOneIsOutput <= 1'b1;
        fire(4'h9);
        quiet("output level change");
        fire(4'hF);
        wait_msg("pulse start", 4'h9, 1'b1);
        $display("line edge test done");
        apb(1'b1, cetu_pkg::OFF_EVT_SEL, 32'h00000000);
        apb(1'b1, cetu_pkg::OFF_NOTIFY, 32'h00000001);
        // clear, then stamp taken when the message loads
        apb(1'b1, cetu_pkg::OFF_CMD, 32'h00000002);
        fire(4'h0);
        wait_msg("stamped event", 4'h0, 1'b0);
        chk("message stamp", msgStamp, 64'h0000000000000002);
        @(posedge clk);
        msgReady <= 1'b0;
        repeat (3) begin
            fire(4'h0);
            repeat (3) @(posedge clk);
        end
        apb(1'b0, cetu_pkg::OFF_STATUS, 32'h00000000);
        chk("overrun status", 64'(rd[1]), 64'h1);
        chk("busy status", 64'(rd[0]), 64'h1);
        rdchk("enable dropped", cetu_pkg::OFF_NOTIFY, 32'h00000000);
        @(posedge clk);
        msgReady <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (!(msgValid === 1'b1 && msgEvent === 4'hA) && i < 30);
        chk("overrun message", 64'(msgEvent), 64'hA);
        chk("overrun legacy", 64'(msgLegacy), 64'h0);
        quiet("drained");
        apb(1'b1, cetu_pkg::OFF_STATUS, 32'h00000002);
        rdchk("status cleared", cetu_pkg::OFF_STATUS, 32'h00000000);
        $display("overrun test done");
        tally_and_finish();
    end
endmodule
